// [rhm_pkg.sv]
package rhm_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFS_CHECK_WINDOW = 8'h00;
  localparam logic [7:0] OFS_PROTO_SELECT = 8'h04;
  localparam logic [7:0] OFS_MS_TIMEOUT = 8'h08;
  localparam logic [7:0] OFS_ERROR_LIMIT = 8'h0c;
  localparam logic [7:0] OFS_MIN_SYNC = 8'h10;
  localparam logic [7:0] OFS_NODE_ACT = 8'h14;
  localparam logic [7:0] OFS_INT_DIVIDER = 8'h18;
  localparam logic [7:0] OFS_AUX_COPY = 8'h1c;
  localparam logic [7:0] OFS_GLOBAL_STATUS = 8'h20;
  localparam logic [7:0] OFS_AUX_CMD = 8'h24;
  localparam logic [7:0] OFS_COUNTS = 8'h28;
  localparam int ADDR_W = 8;

  // Field widths.
  localparam int WINDOW_W = 8;
  localparam int PROTO_W = 16;
  localparam int TIMEOUT_W = 8;
  localparam int LIMIT_W = 8;
  localparam int SYNC_W = 16;
  localparam int DIV_W = 8;
  localparam int NODE_W = 4;
  localparam int NODES = 16;

  // Field positions.
  localparam int SYNC_NODE_LSB = 16;
  localparam int MS_NODE = 15;
  localparam int ST_RING_FAULT = 0;
  localparam int ST_SYNC_SHORT = 1;
  localparam int ST_ERR_LIMIT = 2;
  localparam int ST_CHECK_ACTIVE = 3;
  localparam int ST_AUX_BUSY = 4;
  localparam int ST_AUX_ERROR = 5;
  localparam int CMD_START = 0;
  localparam int CMD_WRITE = 1;

  // Values substituted when a saved threshold is zero at reset.
  localparam logic [LIMIT_W-1:0] ERROR_LIMIT_SUBST = 8'h02;
  localparam logic [SYNC_W-1:0] MIN_SYNC_SUBST = 16'h0002;

  // Flag register placement per node protocol type.
  localparam logic [1:0] FLAG_REG_TYPE0 = 2'h0;
  localparam logic [1:0] FLAG_REG_TYPE1 = 2'h3;
  localparam logic [4:0] FLAG_W_TYPE0 = 5'h18;
  localparam logic [4:0] FLAG_W_TYPE1 = 5'h10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    AUX_IDLE = 2'b01,
    AUX_WAIT = 2'b10
  } rhm_aux_e;

endpackage : rhm_pkg

// [rhm_ctl_if.sv]
interface rhm_ctl_if;
  import rhm_pkg::*;
  logic servo_tick;
  logic [DIV_W-1:0] interrupt_divider;
  logic rti;
  logic [TIMEOUT_W-1:0] ms_timeout;
  logic aux_start;
  logic aux_response;
  logic aux_busy;
  logic aux_timeout;

  modport gen (input servo_tick, input interrupt_divider, output rti);
  modport aux (input servo_tick, input ms_timeout, input aux_start,
    input aux_response, output aux_busy, output aux_timeout);
  modport top (output servo_tick, output interrupt_divider, input rti,
    output ms_timeout, output aux_start, output aux_response,
    input aux_busy, input aux_timeout);
endinterface : rhm_ctl_if

// [rhm_rti_gen.sv]
module rhm_rti_gen
  import rhm_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic rstn,
  // Control link
  rhm_ctl_if.gen ctl
);

  logic [DIV_W-1:0] tick_cnt;

  // One interrupt every interrupt_divider + 1 servo cycles.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      tick_cnt <= '0;
    else if (ctl.servo_tick)
    begin
      if (tick_cnt >= ctl.interrupt_divider)
        tick_cnt <= '0;
      else
        tick_cnt <= tick_cnt + 1'b1;
    end
  end

  assign ctl.rti = ctl.servo_tick && (tick_cnt >= ctl.interrupt_divider);

endmodule : rhm_rti_gen

// [rhm_aux_timer.sv]
module rhm_aux_timer
  import rhm_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic rstn,
  // Control link
  rhm_ctl_if.aux ctl
);

  rhm_aux_e state;
  logic [TIMEOUT_W-1:0] elapsed;
  logic timeout_hit;

  assign timeout_hit = ctl.servo_tick && (elapsed + 1'b1 >= ctl.ms_timeout);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= AUX_IDLE;
      elapsed <= '0;
    end
    else
    begin
      unique case (state)
        AUX_IDLE:
        begin
          elapsed <= '0;
          // A zero timeout keeps the exchange disabled.
          if (ctl.aux_start && ctl.ms_timeout != '0)
            state <= AUX_WAIT;
        end
        AUX_WAIT:
        begin
          if (ctl.aux_response || timeout_hit)
            state <= AUX_IDLE;
          else if (ctl.servo_tick)
            elapsed <= elapsed + 1'b1;
        end
        default:
          state <= AUX_IDLE;
      endcase
    end
  end

  assign ctl.aux_busy = (state == AUX_WAIT);
  assign ctl.aux_timeout = (state == AUX_WAIT) && !ctl.aux_response
    && timeout_hit;

endmodule : rhm_aux_timer

// [rhm_ring_monitor.sv]
// Behaviour
// - Check ring once per periodic check interrupt.
// - Fault disables slaves; active if window nonzero.
// - Sixteen-bit word selects protocol per node.
// - Type0 flags first register, Type1 fourth.
// - Zero timeout disables node 15 exchanges.
// - Timeout without response sets status bit 5.
// - Saved timeout forces copy bit 15 low.
// - Too many errors per window kills motors.
// - At most one error counted per interrupt.
// - Error on every check declares ring fault.
// - Four error classes are counted.
// - Zero error limit at reset becomes 2.
// - Too few sync packets kills motors.
// - At most one sync counted per interrupt.
// - Sync minimum above checks always faults.
// - Sync node from activation bits 16-19.
// - Inactive sync node is an immediate error.
// - Zero sync minimum at reset becomes 2.
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
module rhm_ring_monitor
  import rhm_pkg::*;
#(
  parameter logic [WINDOW_W-1:0] SAVED_CHECK_WINDOW = 8'h00,
  parameter logic [PROTO_W-1:0] SAVED_PROTO_SELECT = 16'h0000,
  parameter logic [TIMEOUT_W-1:0] SAVED_MS_TIMEOUT = 8'h00,
  parameter logic [LIMIT_W-1:0] SAVED_ERROR_LIMIT = 8'h02,
  parameter logic [SYNC_W-1:0] SAVED_MIN_SYNC = 16'h0004,
  parameter logic [31:0] SAVED_NODE_ACT = 32'h0000_0000,
  parameter logic [DIV_W-1:0] SAVED_INT_DIVIDER = 8'h00,
  parameter logic [PROTO_W-1:0] SAVED_AUX_COPY = 16'h0000
)
(
  // System
  input wire logic clk_sys,
  input wire logic rstn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Ring events, one-cycle pulses
  input wire logic servo_tick,
  input wire logic sync_packet,
  input wire logic err_byte_violation,
  input wire logic err_checksum,
  input wire logic err_overrun,
  input wire logic err_underrun,
  input wire logic aux_response,
  // Node flag register lookup
  input wire logic [NODE_W-1:0] flag_node,
  output logic [1:0] flag_reg_index,
  output logic [4:0] flag_reg_width,
  // Outputs to the machine
  output logic kill_motors,
  output logic slave_disable,
  output logic master_slave_cmd,
  output logic master_slave_write_cmd,
  output logic [PROTO_W-1:0] aux_copy_enable_out
);

  localparam logic [LIMIT_W-1:0] RST_ERROR_LIMIT =
    (SAVED_ERROR_LIMIT == '0) ? ERROR_LIMIT_SUBST : SAVED_ERROR_LIMIT;
  localparam logic [SYNC_W-1:0] RST_MIN_SYNC =
    (SAVED_MIN_SYNC == '0) ? MIN_SYNC_SUBST : SAVED_MIN_SYNC;
  localparam logic [PROTO_W-1:0] RST_AUX_COPY = (SAVED_MS_TIMEOUT != '0) ?
    (SAVED_AUX_COPY & ~(16'h0001 << MS_NODE)) : SAVED_AUX_COPY;
  localparam logic CHECK_ACTIVE_RST = (SAVED_CHECK_WINDOW != '0);

  // Merges write data into a register under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = data[i*8 +: 8];
    end
    return res;
  endfunction : merge

  // True when the byte address names a mapped register.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a[1:0] == 2'h0 && a <= OFS_COUNTS;
  endfunction : mapped

  rhm_ctl_if ctl ();

  logic [WINDOW_W-1:0] ring_check_window;
  logic [PROTO_W-1:0] node_protocol_select;
  logic [TIMEOUT_W-1:0] master_slave_timeout;
  logic [LIMIT_W-1:0] ring_error_limit;
  logic [SYNC_W-1:0] min_sync_count;
  logic [31:0] node_activation_config;
  logic [DIV_W-1:0] interrupt_divider;
  logic [PROTO_W-1:0] aux_copy_enable;
  logic check_active;
  logic ring_fault;
  logic sync_short;
  logic err_over;
  logic aux_error;
  logic cmd_write;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] wr_val;

  logic pend_sync;
  logic pend_err;
  logic [WINDOW_W-1:0] window_pos;
  logic [WINDOW_W:0] checks;
  logic [WINDOW_W:0] err_count;
  logic [SYNC_W:0] sync_count;
  logic ring_err_now;
  logic sync_node_inactive;
  logic window_end;
  logic [WINDOW_W:0] next_checks;
  logic [WINDOW_W:0] next_err_count;
  logic [SYNC_W:0] next_sync_count;
  logic fault_sync;
  logic fault_err;
  logic periodic_check_interrupt;

  // Control link to the interrupt divider and the auxiliary timer.
  assign ctl.servo_tick = servo_tick;
  assign ctl.interrupt_divider = interrupt_divider;
  assign ctl.ms_timeout = master_slave_timeout;
  assign ctl.aux_response = aux_response;
  assign ctl.aux_start = do_write && aw_addr == OFS_AUX_CMD
    && w_strb[0] && w_data[CMD_START];
  assign periodic_check_interrupt = ctl.rti;

  rhm_rti_gen u_rti (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ctl(ctl.gen)
  );

  rhm_aux_timer u_aux (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ctl(ctl.aux)
  );

  // AXI4-Lite slave: address and data are taken in either order.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_val = w_data;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFS_CHECK_WINDOW: s_axi_rdata <= 32'(ring_check_window);
        OFS_PROTO_SELECT: s_axi_rdata <= 32'(node_protocol_select);
        OFS_MS_TIMEOUT: s_axi_rdata <= 32'(master_slave_timeout);
        OFS_ERROR_LIMIT: s_axi_rdata <= 32'(ring_error_limit);
        OFS_MIN_SYNC: s_axi_rdata <= 32'(min_sync_count);
        OFS_NODE_ACT: s_axi_rdata <= node_activation_config;
        OFS_INT_DIVIDER: s_axi_rdata <= 32'(interrupt_divider);
        OFS_AUX_COPY: s_axi_rdata <= 32'(aux_copy_enable);
        OFS_GLOBAL_STATUS: s_axi_rdata <= 32'({aux_error, ctl.aux_busy,
          check_active, err_over, sync_short, ring_fault});
        OFS_AUX_CMD: s_axi_rdata <= 32'({cmd_write, ctl.aux_busy});
        OFS_COUNTS: s_axi_rdata <= {sync_count[SYNC_W-1:0],
          err_count[WINDOW_W-1:0], checks[WINDOW_W-1:0]};
        default: s_axi_rdata <= '0;
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Configuration registers; reset values stand for the saved settings.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ring_check_window <= SAVED_CHECK_WINDOW;
      node_protocol_select <= SAVED_PROTO_SELECT;
      master_slave_timeout <= SAVED_MS_TIMEOUT;
      ring_error_limit <= RST_ERROR_LIMIT;
      min_sync_count <= RST_MIN_SYNC;
      node_activation_config <= SAVED_NODE_ACT;
      interrupt_divider <= SAVED_INT_DIVIDER;
      aux_copy_enable <= RST_AUX_COPY;
      cmd_write <= 1'b0;
    end
    else if (do_write)
    begin
      unique case (aw_addr)
        OFS_CHECK_WINDOW: ring_check_window <= WINDOW_W'(merge(
          32'(ring_check_window), wr_val, w_strb));
        OFS_PROTO_SELECT: node_protocol_select <= PROTO_W'(merge(
          32'(node_protocol_select), wr_val, w_strb));
        OFS_MS_TIMEOUT: master_slave_timeout <= TIMEOUT_W'(merge(
          32'(master_slave_timeout), wr_val, w_strb));
        OFS_ERROR_LIMIT: ring_error_limit <= LIMIT_W'(merge(
          32'(ring_error_limit), wr_val, w_strb));
        OFS_MIN_SYNC: min_sync_count <= SYNC_W'(merge(
          32'(min_sync_count), wr_val, w_strb));
        OFS_NODE_ACT: node_activation_config <= merge(
          node_activation_config, wr_val, w_strb);
        OFS_INT_DIVIDER: interrupt_divider <= DIV_W'(merge(
          32'(interrupt_divider), wr_val, w_strb));
        OFS_AUX_COPY: aux_copy_enable <= PROTO_W'(merge(
          32'(aux_copy_enable), wr_val, w_strb));
        OFS_AUX_CMD:
        begin
          if (w_strb[0] && w_data[CMD_START] && !ctl.aux_busy)
            cmd_write <= w_data[CMD_WRITE];
        end
        default: ;
      endcase
    end
  end

  // Checking mode is fixed at reset from the saved window length.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      check_active <= CHECK_ACTIVE_RST;
  end

  assign sync_node_inactive = !node_activation_config[
    node_activation_config[SYNC_NODE_LSB +: NODE_W]];
  assign ring_err_now = err_byte_violation || err_checksum
    || err_overrun || err_underrun;

  // Events between two interrupts collapse to one each.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_sync <= 1'b0;
      pend_err <= 1'b0;
    end
    else if (periodic_check_interrupt)
    begin
      pend_sync <= 1'b0;
      pend_err <= 1'b0;
    end
    else
    begin
      pend_sync <= pend_sync || sync_packet;
      pend_err <= pend_err || ring_err_now;
    end
  end

  assign window_end = servo_tick && check_active
    && ring_check_window != '0 && window_pos + 1'b1 >= ring_check_window;

  always_comb
  begin
    next_checks = checks;
    next_err_count = err_count;
    next_sync_count = sync_count;
    if (periodic_check_interrupt)
    begin
      next_checks = checks + 1'b1;
      if (pend_err || ring_err_now || sync_node_inactive)
        next_err_count = err_count + 1'b1;
      if (pend_sync || sync_packet)
        next_sync_count = sync_count + 1'b1;
    end
  end

  assign fault_err = (next_err_count >= (WINDOW_W+1)'(ring_error_limit))
    || (next_checks != '0 && next_err_count == next_checks);
  assign fault_sync = next_sync_count < (SYNC_W+1)'(min_sync_count);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      window_pos <= '0;
      checks <= '0;
      err_count <= '0;
      sync_count <= '0;
    end
    else if (window_end)
    begin
      window_pos <= '0;
      checks <= '0;
      err_count <= '0;
      sync_count <= '0;
    end
    else
    begin
      if (servo_tick && check_active)
        window_pos <= window_pos + 1'b1;
      checks <= next_checks;
      err_count <= next_err_count;
      sync_count <= next_sync_count;
    end
  end

  // Fault and aux error flags: a new event wins over a clear.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ring_fault <= 1'b0;
      sync_short <= 1'b0;
      err_over <= 1'b0;
      aux_error <= 1'b0;
    end
    else
    begin
      if (window_end && (fault_err || fault_sync))
        ring_fault <= 1'b1;
      else if (do_write && aw_addr == OFS_GLOBAL_STATUS && w_strb[0]
        && w_data[ST_RING_FAULT])
        ring_fault <= 1'b0;
      if (window_end && fault_sync)
        sync_short <= 1'b1;
      else if (do_write && aw_addr == OFS_GLOBAL_STATUS && w_strb[0]
        && w_data[ST_SYNC_SHORT])
        sync_short <= 1'b0;
      if (window_end && fault_err)
        err_over <= 1'b1;
      else if (do_write && aw_addr == OFS_GLOBAL_STATUS && w_strb[0]
        && w_data[ST_ERR_LIMIT])
        err_over <= 1'b0;
      if (ctl.aux_timeout)
        aux_error <= 1'b1;
      else if (do_write && aw_addr == OFS_GLOBAL_STATUS && w_strb[0]
        && w_data[ST_AUX_ERROR])
        aux_error <= 1'b0;
    end
  end

  // Flag register placement for the queried node.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      flag_reg_index <= FLAG_REG_TYPE0;
      flag_reg_width <= FLAG_W_TYPE0;
    end
    else
    begin
      flag_reg_index <= node_protocol_select[flag_node] ?
        FLAG_REG_TYPE1 : FLAG_REG_TYPE0;
      flag_reg_width <= node_protocol_select[flag_node] ?
        FLAG_W_TYPE1 : FLAG_W_TYPE0;
    end
  end

  assign kill_motors = ring_fault;
  assign slave_disable = ring_fault;
  assign master_slave_cmd = ctl.aux_busy;
  assign master_slave_write_cmd = ctl.aux_busy && cmd_write;
  assign aux_copy_enable_out = aux_copy_enable;

endmodule : rhm_ring_monitor

// [rhm_chk_monitor.sv]
module rhm_chk #(
  parameter logic [7:0] SAVED_MS_TIMEOUT = 8'h00
)
(
  // System
  input wire logic clk_sys,
  input wire logic rstn,
  // Observed ports
  input wire logic servo_tick,
  input wire logic aux_response,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] flag_reg_index,
  input wire logic [4:0] flag_reg_width,
  input wire logic kill_motors,
  input wire logic slave_disable,
  input wire logic master_slave_cmd,
  input wire logic master_slave_write_cmd,
  input wire logic [15:0] aux_copy_enable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_kill_slave_tie: assert property (kill_motors == slave_disable)
    else $error("kill and slave disable differ");
  a_flag_reg_pair: assert property (
    (flag_reg_index == 2'h0 && flag_reg_width == 5'h18) ||
    (flag_reg_index == 2'h3 && flag_reg_width == 5'h10))
    else $error("flag register index and width disagree");
  a_copy_bit_forced: assert property (
    (SAVED_MS_TIMEOUT != 8'h00) && $rose(rstn) |-> !aux_copy_enable_out[15])
    else $error("copy bit 15 not forced low");
  a_fault_sticky: assert property ($fell(kill_motors) |-> s_axi_bvalid)
    else $error("fault dropped without a status write");
  a_fault_at_tick: assert property (
    $rose(kill_motors) |-> $past(servo_tick))
    else $error("fault raised away from a servo tick");
  a_aux_start: assert property (
    $rose(master_slave_cmd) |-> s_axi_bvalid)
    else $error("exchange started without a write");
  a_aux_end: assert property (
    $fell(master_slave_cmd) |-> $past(aux_response) || $past(servo_tick))
    else $error("exchange ended without response or tick");
  a_write_type: assert property (
    master_slave_write_cmd |-> master_slave_cmd)
    else $error("write type shown while idle");
endmodule : rhm_chk

bind rhm_ring_monitor rhm_chk #(.SAVED_MS_TIMEOUT(SAVED_MS_TIMEOUT)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .servo_tick(servo_tick),
  .aux_response(aux_response), .s_axi_bvalid(s_axi_bvalid),
  .flag_reg_index(flag_reg_index), .flag_reg_width(flag_reg_width),
  .kill_motors(kill_motors), .slave_disable(slave_disable),
  .master_slave_cmd(master_slave_cmd),
  .master_slave_write_cmd(master_slave_write_cmd),
  .aux_copy_enable_out(aux_copy_enable_out));

// [rhm_ring_nodes.sv]
module rhm_ring_nodes
(
  // System
  input wire logic clk_sys,
  input wire logic rstn,
  // Scenario controls
  input wire logic sync_on,
  input wire logic [3:0] err_on,
  input wire logic reply_on,
  // Ring events
  input wire logic master_slave_cmd,
  output logic servo_tick,
  output logic sync_packet,
  output logic [3:0] err,
  output logic aux_response
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      phase <= 2'h0;
    else
      phase <= phase + 2'h1;
  end

  // Servo cycle of four clocks; two packets and errors per cycle.
  assign servo_tick = (phase == 2'h3);
  assign sync_packet = sync_on && phase[0];
  assign err = err_on & {4{phase[0]}};

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      aux_response <= 1'b0;
    else
      aux_response <= reply_on && master_slave_cmd && !aux_response;
  end
endmodule : rhm_ring_nodes

// [testbench.sv]
module testbench;
  import rhm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, flag_reg_index;
  logic [31:0] s_axi_rdata;
  logic [4:0] flag_reg_width;
  logic [3:0] flag_node = 4'h0, err_on = 4'h0, err;
  logic sync_on = 1'b1, reply_on = 1'b0;
  logic servo_tick, sync_packet, aux_response, kill_motors, slave_disable;
  logic master_slave_cmd, master_slave_write_cmd;
  logic [15:0] aux_copy_enable_out;
  int miscompares = 0;
  int n_tests = 0;

  always #5 clk_sys = ~clk_sys;

  rhm_ring_monitor #(.SAVED_CHECK_WINDOW(8'h04),
    .SAVED_MS_TIMEOUT(8'h03), .SAVED_ERROR_LIMIT(8'h00),
    .SAVED_MIN_SYNC(16'h0000), .SAVED_AUX_COPY(16'hffff)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .servo_tick(servo_tick), .sync_packet(sync_packet),
    .err_byte_violation(err[0]), .err_checksum(err[1]),
    .err_overrun(err[2]), .err_underrun(err[3]),
    .aux_response(aux_response), .flag_node(flag_node),
    .flag_reg_index(flag_reg_index), .flag_reg_width(flag_reg_width),
    .kill_motors(kill_motors), .slave_disable(slave_disable),
    .master_slave_cmd(master_slave_cmd),
    .master_slave_write_cmd(master_slave_write_cmd),
    .aux_copy_enable_out(aux_copy_enable_out));

  rhm_ring_nodes u_nodes (.clk_sys(clk_sys), .rstn(rstn),
    .sync_on(sync_on), .err_on(err_on), .reply_on(reply_on),
    .master_slave_cmd(master_slave_cmd), .servo_tick(servo_tick),
    .sync_packet(sync_packet), .err(err), .aux_response(aux_response));

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] resp);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] resp);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic reset_values;
    logic [31:0] rd;
    logic [1:0] rr;
    axi_write(OFS_NODE_ACT, 32'h0003_0008, rr);
    chk("write resp", {30'h0, rr}, {30'h0, RESP_OKAY});
    axi_read(OFS_ERROR_LIMIT, rd, rr);
    chk("error limit", rd, 32'h2);
    axi_read(OFS_MIN_SYNC, rd, rr);
    chk("min sync", rd, 32'h2);
    axi_read(OFS_AUX_COPY, rd, rr);
    chk("aux copy", {rd[15:0], aux_copy_enable_out}, 32'h7fff_7fff);
    axi_read(OFS_GLOBAL_STATUS, rd, rr);
    chk("check active", {28'h0, rd[3:0]}, 32'h8);
    axi_read(8'h2c, rd, rr);
    chk("unmapped", {rd[29:0], rr}, {30'h0, RESP_SLVERR});
    axi_read(OFS_COUNTS, rd, rr);
    chk("one sync per check", {16'h0, rd[31:16]}, {24'h0, rd[7:0]});
  endtask : reset_values

  task automatic proto_select;
    logic [31:0] rd;
    logic [1:0] rr;
    axi_write(OFS_PROTO_SELECT, 32'h0000_80a5, rr);
    axi_read(OFS_PROTO_SELECT, rd, rr);
    chk("proto select", rd, 32'h0000_80a5);
    for (int n = 0; n < NODES; n++)
    begin
      @(posedge clk_sys);
      flag_node <= 4'(n);
      repeat (2) @(posedge clk_sys);
      rd[0] = (32'h80a5 >> n) & 32'h1;
      chk("flag reg", {25'h0, flag_reg_index, flag_reg_width},
        rd[0] ? 32'h70 : 32'h18);
    end
  endtask : proto_select

  task automatic fault_case(input string name, input logic [7:0] a,
    input logic [31:0] bad, input logic [31:0] good, input logic s_on,
    input logic [3:0] e_on, input int sbit);
    logic [31:0] rd;
    logic [1:0] rr;
    axi_write(a, bad, rr);
    sync_on <= s_on;
    err_on <= e_on;
    repeat (48) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(name, {30'h0, slave_disable, kill_motors}, 32'h3);
    axi_read(OFS_GLOBAL_STATUS, rd, rr);
    chk(name, {31'h0, rd[sbit]}, 32'h1);
    sync_on <= 1'b1;
    err_on <= 4'h0;
    axi_write(a, good, rr);
    repeat (32) @(posedge clk_sys);
    axi_write(OFS_GLOBAL_STATUS, 32'h7, rr);
    repeat (24) @(negedge clk_sys);
    chk(name, {31'h0, kill_motors}, 32'h0);
  endtask : fault_case

  task automatic aux_exchange;
    logic [31:0] rd;
    logic [1:0] rr;
    int n;
    axi_write(OFS_AUX_CMD, 32'h3, rr);
    @(negedge clk_sys);
    chk("aux start", {master_slave_cmd, master_slave_write_cmd}, 2'b11);
    for (n = 0; master_slave_cmd && n < 40; n++)
      @(negedge clk_sys);
    chk("aux timeout span", (n >= 8 && n <= 11), 1'b1);
    axi_read(OFS_GLOBAL_STATUS, rd, rr);
    chk("aux error", {31'h0, rd[5]}, 32'h1);
    axi_write(OFS_GLOBAL_STATUS, 32'h20, rr);
    reply_on <= 1'b1;
    axi_write(OFS_AUX_CMD, 32'h1, rr);
    for (n = 0; master_slave_cmd && n < 40; n++)
      @(negedge clk_sys);
    axi_read(OFS_GLOBAL_STATUS, rd, rr);
    chk("aux answered", {n < 4, rd[5]}, 2'b10);
    axi_write(OFS_MS_TIMEOUT, 32'h0, rr);
    axi_write(OFS_AUX_CMD, 32'h1, rr);
    @(negedge clk_sys);
    chk("aux disabled", {31'h0, master_slave_cmd}, 32'h0);
    axi_write(OFS_MS_TIMEOUT, 32'h20, rr);
  endtask : aux_exchange

  initial
  begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    reset_values();
    proto_select();
    fault_case("no sync", OFS_MIN_SYNC, 2, 2, 0, 4'h0, 1);
    fault_case("min above checks", OFS_MIN_SYNC, 5, 2, 1, 4'h0, 1);
    fault_case("inactive node", OFS_NODE_ACT, 32'h0003_0000,
      32'h0003_0008, 1, 4'h0, 2);
    for (int k = 0; k < 4; k++)
      fault_case("error class", OFS_MIN_SYNC, 2, 2, 1, 4'h1 << k, 2);
    aux_exchange();
    report_and_stop();
  end

  initial
  begin
    #200000;
    miscompares++;
    report_and_stop();
  end
endmodule : testbench
